// ### rtl/fe_codec.v
// 100BASE-TX coding path: 4B/5B, scrambling, NRZI and MLT-3 split
`include "fe_codec_regs.vh"
`default_nettype none
// Contract
// - NRZI encode after serialise and scramble
// - NRZI stage always active, no bypass
// - Idle 11111 gives receive nibble 0000
// - SSD is 11000 10001, nibble 0101
// - ESD is 01101 00111, nibble 0000
// - Code 00100 is halt, an error
// - Undefined code gives nibble 6, RX_ER
// - Control code inside data gives RX_ER
// - MLT-3 ones alternate plus and minus
// - Line output only MLT-3, no binary
// - TX_ER with TX_EN sends halt codes
// - Delimiters kept during error substitution
// - Receiver delivers synchronous nibbles to MAC
// - Fast link pulses never assert signal detect
// - Equaliser gain adapts to cable attenuation
// - Scrambler LFSR XOR before NRZI
// - Align code-groups at SSD, then hold
module fe_codec (
   input wire clk_in,
   input wire nrst_in,
   input wire [3:0] txd_in,
   input wire tx_en_in,
   input wire tx_er_in,
   input wire line_rx_pair_b_in,
   input wire [7:0] rx_level_in,
   output reg nib_tick_out,
   output reg [3:0] rxd_out,
   output reg rx_dv_out,
   output reg rx_er_out,
   output reg line_tx_pair_a_p_out,
   output reg line_tx_pair_a_n_out,
   output reg signal_detect_out,
   output reg [7:0] eq_gain_out
);
// ==================================================
// Symbol timing: one bit per clock, five per code-group
   reg [2:0] bit_cnt_q;
   wire cg_tick = (bit_cnt_q == 3'd4);
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         bit_cnt_q <= 3'd0;
         nib_tick_out <= 1'b0;
      end else begin
         bit_cnt_q <= cg_tick ? 3'd0 : bit_cnt_q + 3'd1;
         nib_tick_out <= cg_tick;
      end
   end
// ==================================================
// Shared lookup
   wire [4:0] data_cg;
   wire [3:0] dec_nib;
   wire dec_ok;
   reg [4:0] rx_cg_q;
   fe_codec_tables u_tables (
      .nib_in(txd_in),
      .cg_in(rx_cg_q),
      .cg_out(data_cg),
      .nib_out(dec_nib),
      .valid_out(dec_ok)
   );
// ==================================================
// Transmit framing: J, K replace first preamble octet; T, R close
   localparam TX_IDLE = 3'd0;
   localparam TX_K = 3'd1;
   localparam TX_DATA = 3'd2;
   localparam TX_R = 3'd3;
   localparam TX_J = 3'd4;
   reg [2:0] tx_st_q;
   reg [4:0] tx_cg_q;
   reg [4:0] tx_sh_q;
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         tx_st_q <= TX_IDLE;
         tx_cg_q <= `CG_IDLE;
      end else if (cg_tick) begin
         case (tx_st_q)
            TX_IDLE: begin
               if (tx_en_in) begin
                  tx_cg_q <= `CG_SSD1;
                  tx_st_q <= TX_K;
               end else begin
                  tx_cg_q <= `CG_IDLE;
               end
            end
            TX_K: begin
               tx_cg_q <= `CG_SSD2;
               tx_st_q <= TX_DATA;
            end
            TX_DATA: begin
               if (!tx_en_in) begin
                  tx_cg_q <= `CG_ESD1;
                  tx_st_q <= TX_R;
               end else if (tx_er_in) begin
                  tx_cg_q <= `CG_HALT;
               end else begin
                  tx_cg_q <= data_cg;
               end
            end
            TX_R: begin
               tx_cg_q <= `CG_ESD2;
               tx_st_q <= TX_IDLE;
            end
            default: begin
               tx_cg_q <= `CG_IDLE;
               tx_st_q <= TX_IDLE;
            end
         endcase
      end
   end
// ==================================================
// Serialise, scramble, NRZI and MLT-3 split; no bypass path exists
   reg [10:0] scr_q;
   reg nrzi_q;
   reg nrzi_p_q;
   reg mlt_sel_q;
   wire scr_bit = tx_sh_q[4] ^ scr_q[10];
   // MLT-3 works from the NRZI stream: a level change is its logic-one event
   wire one_evt = nrzi_q ^ nrzi_p_q;
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         tx_sh_q <= `CG_IDLE;
         scr_q <= `SCR_SEED;
         nrzi_q <= 1'b0;
         nrzi_p_q <= 1'b0;
         mlt_sel_q <= 1'b0;
         line_tx_pair_a_p_out <= 1'b0;
         line_tx_pair_a_n_out <= 1'b0;
      end else begin
         tx_sh_q <= cg_tick ? tx_cg_q : {tx_sh_q[3:0], 1'b0};
         // x^11 + x^9 + 1 closed-loop sequence
         scr_q <= {scr_q[9:0], scr_q[10] ^ scr_q[8]};
         nrzi_q <= nrzi_q ^ scr_bit;
         nrzi_p_q <= nrzi_q;
         // Each one alternates between the plus and minus streams
         line_tx_pair_a_p_out <= one_evt & ~mlt_sel_q;
         line_tx_pair_a_n_out <= one_evt & mlt_sel_q;
         if (one_evt) begin
            mlt_sel_q <= ~mlt_sel_q;
         end
      end
   end
// ==================================================
// Receive input synchroniser; line stream is already descrambled NRZ
   reg rx_s1_q;
   reg rx_s2_q;
   reg [9:0] rx_win_q;
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         rx_s1_q <= 1'b0;
         rx_s2_q <= 1'b0;
         rx_win_q <= 10'h3ff;
      end else begin
         rx_s1_q <= line_rx_pair_b_in;
         rx_s2_q <= rx_s1_q;
         rx_win_q <= {rx_win_q[8:0], rx_s2_q};
      end
   end
// ==================================================
// Alignment: free until SSD seen, then boundary fixed
   localparam RX_HUNT = 2'd0;
   localparam RX_K = 2'd1;
   localparam RX_DATA = 2'd2;
   localparam RX_R = 2'd3;
   reg [1:0] rx_st_q;
   reg [2:0] rx_cnt_q;
   reg [4:0] rx_prev_q;
   wire ssd_seen = (rx_win_q == {`CG_SSD1, `CG_SSD2});
   wire rx_tick = (rx_cnt_q == 3'd4);
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         rx_st_q <= RX_HUNT;
         rx_cnt_q <= 3'd0;
         rx_cg_q <= `CG_IDLE;
         rx_prev_q <= `CG_IDLE;
         rxd_out <= `NIB_ZERO;
         rx_dv_out <= 1'b0;
         rx_er_out <= 1'b0;
      end else if (rx_st_q == RX_HUNT) begin
         rxd_out <= `NIB_ZERO;
         rx_dv_out <= 1'b0;
         rx_er_out <= 1'b0;
         if (ssd_seen) begin
            rx_st_q <= RX_K;
            rx_cnt_q <= 3'd0;
            rx_cg_q <= `CG_SSD2; // A stale idle must not count toward the two-idle end
            rxd_out <= `NIB_PRE;
            rx_dv_out <= 1'b1;
         end
      end else begin
         rx_cnt_q <= rx_tick ? 3'd0 : rx_cnt_q + 3'd1;
         if (rx_tick) begin
            rx_cg_q <= rx_win_q[4:0];
            rx_prev_q <= rx_cg_q;
         end
         // Decode the group latched one bit time after its boundary
         if (rx_cnt_q == 3'd0) begin
            case (rx_st_q)
               RX_K: begin
                  rxd_out <= `NIB_PRE;
                  rx_st_q <= RX_DATA;
               end
               RX_DATA: begin
                  if (rx_cg_q == `CG_ESD1) begin
                     rxd_out <= `NIB_ZERO;
                     rx_er_out <= 1'b0;
                     rx_st_q <= RX_R;
                  end else if (rx_cg_q == `CG_IDLE && rx_prev_q == `CG_IDLE) begin
                     rxd_out <= `NIB_ZERO;
                     rx_dv_out <= 1'b0;
                     rx_er_out <= 1'b0;
                     rx_st_q <= RX_HUNT;
                  end else if (dec_ok) begin
                     rxd_out <= dec_nib;
                     rx_er_out <= 1'b0;
                  end else begin
                     // Halt, undefined, or control inside data
                     rxd_out <= `NIB_INVALID;
                     rx_er_out <= 1'b1;
                  end
               end
               RX_R: begin
                  rxd_out <= `NIB_ZERO;
                  rx_er_out <= (rx_cg_q != `CG_ESD2);
                  rx_dv_out <= 1'b0;
                  rx_st_q <= RX_HUNT;
               end
               default: rx_st_q <= RX_HUNT;
            endcase
         end
      end
   end
// ==================================================
// Signal detect: short link pulses never last long enough to qualify
   reg [7:0] sd_cnt_q;
   reg [7:0] lvl_s1_q;
   reg [7:0] lvl_s2_q;
   always @(posedge clk_in) begin
      if (!nrst_in) begin
         lvl_s1_q <= 8'h00;
         lvl_s2_q <= 8'h00;
         sd_cnt_q <= 8'h00;
         signal_detect_out <= 1'b0;
         eq_gain_out <= 8'h80;
      end else begin
         lvl_s1_q <= rx_level_in;
         lvl_s2_q <= lvl_s1_q;
         if (lvl_s2_q == 8'h00) begin
            sd_cnt_q <= 8'h00;
         end else if (sd_cnt_q != `SD_HOLD) begin
            sd_cnt_q <= sd_cnt_q + 8'h01;
         end
         signal_detect_out <= (sd_cnt_q == `SD_HOLD);
         // Behavioural loop: step gain toward a mid-scale amplitude
         if (cg_tick && lvl_s2_q != 8'h00) begin
            if (lvl_s2_q < 8'h80 && eq_gain_out != 8'hff) begin
               eq_gain_out <= eq_gain_out + 8'h01;
            end else if (lvl_s2_q > 8'h80 && eq_gain_out != 8'h00) begin
               eq_gain_out <= eq_gain_out - 8'h01;
            end
         end
      end
   end
endmodule // fe_codec
`default_nettype wire

// ### rtl/fe_codec_regs.vh
// Constants for the 100BASE-TX 4B/5B, NRZI and MLT-3 coding path
`ifndef FE_CODEC_REGS_VH
`define FE_CODEC_REGS_VH
// ==================================================
// Control code-groups
`define CG_IDLE 5'h1f
`define CG_SSD1 5'h18
`define CG_SSD2 5'h11
`define CG_ESD1 5'h0d
`define CG_ESD2 5'h07
`define CG_HALT 5'h04
// ==================================================
// Receive nibbles
`define NIB_PRE 4'h5
`define NIB_ZERO 4'h0
`define NIB_INVALID 4'h6
// ==================================================
// Scrambler
`define SCR_LEN 11
`define SCR_SEED 11'h7ff
// ==================================================
// Signal detect: energy must persist this many clocks
`define SD_HOLD 8'h40
`endif

// ### rtl/fe_codec_tables.v
// 4B/5B code table lookup used by both the transmit and receive paths
`include "fe_codec_regs.vh"
`default_nettype none
module fe_codec_tables (
   input wire [3:0] nib_in,
   input wire [4:0] cg_in,
   output wire [4:0] cg_out,
   output wire [3:0] nib_out,
   output wire valid_out
);
// ==================================================
// Data code mapping both directions
   function [4:0] enc;
      input [3:0] n;
      begin
         case (n)
            4'h0: enc = 5'h1e;
            4'h1: enc = 5'h09;
            4'h2: enc = 5'h14;
            4'h3: enc = 5'h15;
            4'h4: enc = 5'h0a;
            4'h5: enc = 5'h0b;
            4'h6: enc = 5'h0e;
            4'h7: enc = 5'h0f;
            4'h8: enc = 5'h12;
            4'h9: enc = 5'h13;
            4'ha: enc = 5'h16;
            4'hb: enc = 5'h17;
            4'hc: enc = 5'h1a;
            4'hd: enc = 5'h1b;
            4'he: enc = 5'h1c;
            default: enc = 5'h1d;
         endcase
      end
   endfunction
   reg [3:0] dec_n;
   reg dec_v;
   integer i;
   // Reverse lookup by search keeps one table as the sole truth
   always @* begin
      dec_n = `NIB_INVALID;
      dec_v = 1'b0;
      for (i = 0; i < 16; i = i + 1) begin
         if (enc(i[3:0]) == cg_in) begin
            dec_n = i[3:0];
            dec_v = 1'b1;
         end
      end
   end
   assign cg_out = enc(nib_in);
   assign nib_out = dec_n;
   assign valid_out = dec_v;
endmodule // fe_codec_tables
`default_nettype wire

// ### tb/fe_codec_assertions.sv
// Concurrent checks on the codec's ports
`default_nettype none
module fe_codec_checker (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [7:0] rx_level_in,
   input wire logic nib_tick_out,
   input wire logic [3:0] rxd_out,
   input wire logic rx_dv_out,
   input wire logic rx_er_out,
   input wire logic line_tx_pair_a_p_out,
   input wire logic line_tx_pair_a_n_out,
   input wire logic signal_detect_out,
   input wire logic [7:0] eq_gain_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] last_q; // Last pulse stream: 0 none, 1 plus, 2 minus
   logic [7:0] nz_q; // Saturating run of nonzero level cycles
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   // ==================================================
   // Helpers
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         last_q <= 2'd0;
         nz_q <= 8'h00;
      end else begin
         if (line_tx_pair_a_p_out) last_q <= 2'd1;
         else if (line_tx_pair_a_n_out) last_q <= 2'd2;
         if (rx_level_in == 8'h00) nz_q <= 8'h00;
         else if (nz_q != 8'hff) nz_q <= nz_q + 8'h01;
      end
   end
   // ==================================================
   // Properties
   tick_period_a: assert property (
      nib_tick_out |=> !nib_tick_out [*4] ##1 nib_tick_out) else $error("tick spacing");
   mlt_excl_a: assert property (
      !(line_tx_pair_a_p_out && line_tx_pair_a_n_out)) else $error("both streams high");
   mlt_alt_a: assert property (
      (line_tx_pair_a_p_out |-> last_q != 2'd1) and (line_tx_pair_a_n_out |-> last_q != 2'd2))
      else $error("pulses do not alternate");
   sd_fast_a: assert property (
      $rose(signal_detect_out) |-> $past(nz_q, 3) >= 8'd56) else $error("early detect");
   eq_step_a: assert property (
      !$stable(eq_gain_out) |-> eq_gain_out == 8'($past(eq_gain_out) + 8'd1)
      || eq_gain_out == 8'($past(eq_gain_out) - 8'd1)) else $error("gain jump");
   eq_group_a: assert property (
      !$stable(eq_gain_out) |=> $stable(eq_gain_out) [*4]) else $error("gain too fast");
   rx_hold_a: assert property (
      rx_dv_out && $changed({rxd_out, rx_dv_out, rx_er_out})
      |=> $stable({rxd_out, rx_dv_out, rx_er_out}) [*4]) else $error("nibble held short");
   frame_start_a: assert property (
      $rose(rx_dv_out) |-> rxd_out == 4'h5 && !rx_er_out) else $error("bad first nibble");
endmodule // fe_codec_checker
bind fe_codec fe_codec_checker chk (.clk_in, .nrst_in, .rx_level_in, .nib_tick_out,
   .rxd_out, .rx_dv_out, .rx_er_out, .line_tx_pair_a_p_out, .line_tx_pair_a_n_out,
   .signal_detect_out, .eq_gain_out);
`default_nettype wire

// ### tb/mii_mac_model.sv
// Transmit side of a MAC on the MII
`default_nettype none
module mii_mac_model (
   input wire logic clk_in,
   input wire logic nib_tick_in,
   output var logic [3:0] txd_out,
   output var logic tx_en_out,
   output var logic tx_er_out,
   output var logic fault_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      txd_out = 4'h0;
      tx_en_out = 1'b0;
      tx_er_out = 1'b0;
      fault_out = 1'b0;
   end
   // Next nibble slot; a missing tick is flagged rather than hanging
   task automatic next_slot;
      int n;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (nib_tick_in !== 1'b1 && n < 20);
      if (n >= 20) fault_out = 1'b1;
   endtask
   // First two slots become the start delimiter inside the device
   task automatic send_frame(input int len, input int err_at);
      for (int i = 0; i < len; i++) begin
         next_slot();
         txd_out <= i[3:0];
         tx_en_out <= 1'b1;
         tx_er_out <= (i == err_at);
      end
      next_slot();
      tx_en_out <= 1'b0;
      tx_er_out <= 1'b0;
   endtask
endmodule // mii_mac_model
`default_nettype wire

// ### tb/fast_ethernet_4b5b_mlt3_codec_test.sv
// Self-checking bench for the 100BASE-TX codec
`default_nettype none
`include "fe_codec_regs.vh"
module fast_ethernet_4b5b_mlt3_codec_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0, nrst_in = 1'b0, line_rx_pair_b_in = 1'b0, fault;
   logic [7:0] rx_level_in = 8'h00, eq_gain_out;
   logic [3:0] txd_in, rxd_out;
   logic tx_en_in, tx_er_in, nib_tick_out, rx_dv_out, rx_er_out, signal_detect_out;
   logic line_tx_pair_a_p_out, line_tx_pair_a_n_out;
   int error_cnt = 0, num_checks = 0, cap_cnt = 0, pulses = 0;
   logic [4:0] cap_q[$]; // Error flag above nibble
   logic [4:0] txq[$]; // Code-groups recovered from the line after a start pair
   logic [10:0] lf; // Local copy of the transmit scrambler
   logic [2:0] hm; // Scrambler output history, matches the line delay
   logic [9:0] tw; // Recovered serial window
   int tcnt = -1;
   localparam logic [4:0] CODE [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e,
      5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
   fe_codec dut (.clk_in, .nrst_in, .txd_in, .tx_en_in, .tx_er_in, .line_rx_pair_b_in,
      .rx_level_in, .nib_tick_out, .rxd_out, .rx_dv_out, .rx_er_out, .line_tx_pair_a_p_out,
      .line_tx_pair_a_n_out, .signal_detect_out, .eq_gain_out);
   mii_mac_model mac (.clk_in, .nib_tick_in(nib_tick_out), .txd_out(txd_in),
      .tx_en_out(tx_en_in), .tx_er_out(tx_er_in), .fault_out(fault));
   initial forever #2.5 clk_in = ~clk_in;
   // ==================================================
   // Monitors: one entry per nibble slot while valid, and line pulses
   always @(posedge clk_in) begin
      pulses += int'(line_tx_pair_a_p_out | line_tx_pair_a_n_out);
      // Undo MLT-3, NRZI and scrambling, then cut groups after the start pair
      if (nrst_in !== 1'b1) begin
         lf = `SCR_SEED;
         hm = 3'b111;
         tw = 10'h3ff;
         tcnt = -1;
      end else begin
         hm = {hm[1:0], lf[10]};
         tw = {tw[8:0], hm[2] ^ (line_tx_pair_a_p_out | line_tx_pair_a_n_out)};
         lf = {lf[9:0], lf[10] ^ lf[8]};
         if (tcnt >= 0) begin
            tcnt++;
            if (tcnt == 5) begin
               txq.push_back(tw[4:0]);
               tcnt = (tw[4:0] == `CG_ESD2) ? -1 : 0;
            end
         end else if (tw == {`CG_SSD1, `CG_SSD2}) tcnt = 0;
      end
      if (rx_dv_out === 1'b1) begin
         if (cap_cnt == 0) cap_q.push_back({rx_er_out, rxd_out});
         cap_cnt = (cap_cnt == 4) ? 0 : cap_cnt + 1;
      end else cap_cnt = 0;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ==================================================
   // Stimulus helpers
   task automatic send_cg(input logic [4:0] cg);
      for (int i = 4; i >= 0; i--) begin
         @(posedge clk_in);
         line_rx_pair_b_in <= cg[i];
      end
   endtask
   // Idles, start pair, body, end pair if esd, idles; then compare the nibbles seen
   task automatic rx_frame(input logic [4:0] cgs[$], input logic [4:0] exp[$], input bit esd);
      cap_q.delete();
      repeat (4) send_cg(`CG_IDLE);
      send_cg(`CG_SSD1);
      send_cg(`CG_SSD2);
      foreach (cgs[i]) send_cg(cgs[i]);
      if (esd) begin
         send_cg(`CG_ESD1);
         send_cg(`CG_ESD2);
      end
      repeat (4) send_cg(`CG_IDLE);
      chk(rx_dv_out, 0, "valid after end");
      chk(rxd_out, `NIB_ZERO, "idle nibble");
      foreach (exp[i]) chk(cap_q[i], exp[i], "nibble");
   endtask
   // ==================================================
   // Scenarios
   task automatic do_reset;
      nrst_in <= 1'b0;
      repeat (20) @(posedge clk_in);
      chk(eq_gain_out, 8'h80, "gain reset");
      chk({rx_dv_out, rx_er_out, signal_detect_out}, 0, "flags reset");
      nrst_in <= 1'b1;
      $display("test reset done");
   endtask
   task automatic t_level;
      int n;
      repeat (10) begin
         rx_level_in <= 8'h60;
         repeat (3) @(posedge clk_in);
         rx_level_in <= 8'h00;
         repeat (30) @(posedge clk_in);
         chk(signal_detect_out, 0, "detect on pulses");
      end
      rx_level_in <= 8'h20;
      for (n = 0; n < 100 && signal_detect_out !== 1'b1; n++) @(posedge clk_in);
      chk(signal_detect_out, 1, "detect on energy");
      repeat (300) @(posedge clk_in);
      chk(eq_gain_out > 8'h80, 1, "gain up on long cable");
      rx_level_in <= 8'hf0;
      repeat (700) @(posedge clk_in);
      chk(eq_gain_out < 8'h80, 1, "gain down on short cable");
      rx_level_in <= 8'h80;
      $display("test level done");
   endtask
   task automatic t_rx_data;
      logic [4:0] c[$], e[$];
      e = '{5'h05, 5'h05};
      for (int i = 0; i < 16; i++) begin
         c.push_back(CODE[i]);
         e.push_back(5'(i));
      end
      rx_frame(c, e, 1'b1);
      $display("test rx data done");
   endtask
   task automatic t_rx_bad;
      rx_frame('{CODE[3], 5'h00, 5'h19, `CG_IDLE, `CG_SSD1, CODE[7]},
         '{5'h05, 5'h05, 5'h03, 5'h16, 5'h16, 5'h16, 5'h16, 5'h07}, 1'b1);
      // Frame cut by idles: the first idle is an error, the second ends it
      rx_frame('{CODE[9]}, '{5'h05, 5'h05, 5'h09, 5'h16}, 1'b0);
      $display("test rx bad done");
   endtask
   // One transmit frame, then the recovered groups against the nibbles sent
   task automatic tx_frame(input int len, input int err_at);
      logic [4:0] e[$];
      txq.delete();
      mac.send_frame(len, err_at);
      repeat (40) @(posedge clk_in);
      for (int i = 2; i < len; i++) e.push_back((i == err_at) ? `CG_HALT : CODE[i]);
      e.push_back(`CG_ESD1);
      e.push_back(`CG_ESD2);
      chk(8'(txq.size()), 8'(e.size()), "tx groups");
      foreach (e[i]) chk(txq[i], e[i], "tx group");
   endtask
   task automatic t_tx;
      tx_frame(10, -1);
      tx_frame(10, 1);
      tx_frame(8, 4);
      chk(fault, 0, "nibble tick");
      chk(pulses != 0, 1, "line pulses");
      $display("test tx done");
   endtask
   initial begin
      repeat (100000) @(posedge clk_in);
      error_cnt++;
      $display("MISMATCH t=%0t timeout", $time);
      finish_test();
   end
   initial begin
      do_reset();
      t_level();
      t_rx_data();
      t_rx_bad();
      t_tx();
      do_reset();
      t_tx();
      finish_test();
   end
endmodule // fast_ethernet_4b5b_mlt3_codec_test
`default_nettype wire
